// file: rtl/srp_pkg.sv
/*
 * shared constants of the supervisor reset and power-good block:
 * register map, field positions, reset values and timing counts.
 * assumes a 250 MHz core clock.
 */
package srp_pkg;

    // ********************************************************
    // clock and timing
    // ********************************************************
    localparam int CLK_MHZ         = 250;
    localparam int RESET_HOLD_US   = 25;
    localparam int POK_DELAY_US    = 10;
    localparam int RESET_HOLD_CYC  = RESET_HOLD_US * CLK_MHZ;
    localparam int POK_DELAY_CYC   = POK_DELAY_US * CLK_MHZ;
    localparam int CNT_W           = 20;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_PG_THR   = 8'h10;

    // ********************************************************
    // control fields
    // ********************************************************
    localparam int CTRL_RAIL_LSB  = 0;
    localparam int CTRL_RST_LSB   = 4;
    localparam int CTRL_POK_LSB   = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h0f;
    localparam logic [15:0] PG_THR_RESET  = 16'h0000;

    // ********************************************************
    // status and interrupt fields
    // ********************************************************
    localparam int ST_PG_LSB     = 0;
    localparam int ST_RST_BIT    = 4;
    localparam int ST_MARGIN_BIT = 5;
    localparam int ST_ADDR_LSB   = 6;
    localparam int ST_FSM_LSB    = 8;
    localparam int IRQ_PGLOST_LSB = 0;
    localparam int IRQ_RST_BIT    = 4;
    localparam int IRQ_MARGIN_BIT = 5;
    localparam int IRQ_W          = 6;

    typedef enum logic [1:0] {
        SRP_RST_HOLD,
        SRP_RST_TIMING,
        SRP_RST_RUN
    } srp_rst_state_t;

endpackage

// file: rtl/srp_persist.sv
/*
 * persistence filter: ok rises once cond has held for more than
 * len cycles, and drops at once with cond.
 * assumes cond synchronous to core_clk.
 */
`timescale 1ns/1ps
module srp_persist
    import srp_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // condition and length
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] len,
    // result
    output logic                  ok_q
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             ok_d;

    always_comb
    begin
        cnt_d = cnt_q;
        ok_d  = 1'b0;
        if (!cond)
        begin
            cnt_d = '0;
        end
        // once good, a longer len written later does not drop ok
        else if (ok_q || (cnt_q > len))
        begin
            ok_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            ok_q  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            ok_q  <= ok_d;
        end
    end
endmodule

// file: rtl/srp_margin_hold.sv
/*
 * one rail reading with margin freeze: while freeze is high the
 * last reading taken before it is held.
 * assumes synchronous inputs.
 */
`timescale 1ns/1ps
module srp_margin_hold
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // reading
    input  wire logic freeze,
    input  wire logic reading,
    // effective reading
    output logic      eff_q
);
    logic eff_d;

    always_comb
    begin
        eff_d = freeze ? eff_q : reading;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            eff_q <= 1'b0;
        end
        else
        begin
            eff_q <= eff_d;
        end
    end
endmodule

// file: rtl/srp_top.sv
/*
 * supervisor output logic: manual reset stretch, margin freeze,
 * per-rail power-good persistence, address strap capture, APB
 * register file and interrupt.
 * assumes analog comparators deliver synchronous readings and that
 * an APB master drives the bus on core_clk.
 */
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps

// Summary of operation
// [R1] margin low freezes readings for tracking, reset
// [R2] margin high resumes normal supply monitoring
// [R3] host asserts margin after normal power-up
// [R4] manual reset low holds reset, then timeout
// [R5] sample two address straps for bus address
// [R6] power-good low until rail persists over delay
// [R7] each power-good reports its own rail only
// [R8] reset low while tracking, until rails good
// [R9] rail dropping early restarts its persistence timer
module srp_top
    import srp_pkg::*;
#(
    parameter int RST_HOLD_CYC = srp_pkg::RESET_HOLD_CYC,
    parameter int POK_CYC      = srp_pkg::POK_DELAY_CYC
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // system pins
    input  wire logic        manual_reset_n,
    input  wire logic        margin_n,
    input  wire logic        addr_select0,
    input  wire logic        addr_select1,
    output logic             system_reset_n,
    output logic             power_good_rail1,
    output logic             power_good_rail2,
    output logic             power_good_rail3,
    output logic             power_good_rail4,
    // analog and tracking side
    input  wire logic [3:0]  rail_in_window,
    input  wire logic [3:0]  supply_out_of_range,
    input  wire logic        tracking_busy,
    output logic [3:0]       supply_fault,
    output logic [15:0]      pg_threshold,
    output logic [1:0]       bus_addr,
    // interrupt
    output logic             irq
);
    import srp_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    logic [7:0]        ctrl_q, ctrl_d;
    logic [15:0]       thr_q, thr_d;
    logic [IRQ_W-1:0]  istat_q, istat_d;
    logic [IRQ_W-1:0]  imask_q, imask_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              rdy_q, rdy_d;
    logic              err_q, err_d;
    logic              irq_q, irq_d;
    logic [1:0]        addr_q, addr_d;
    logic              addr_done_q, addr_done_d;
    logic [3:0]        fault_q, fault_d;
    logic [3:0]        pg_prev_q;
    logic              sysrst_q, sysrst_d;
    logic              margin_prev_q;
    srp_rst_state_t    rst_st_q, rst_st_d;

    logic              freeze;
    logic [3:0]        rail_eff;
    logic [3:0]        pg_ok;
    logic              rst_done;
    logic              hold_req;
    logic [CNT_W-1:0]  pok_len;
    logic [CNT_W-1:0]  rst_len;
    logic              wr_acc;
    logic              setup;
    logic [3:0]        rail_sel;

    // ********************************************************
    // margin freeze and rail filters
    // ********************************************************
    assign freeze   = ~margin_n;                     // [R1] [R2]
    assign rail_sel = ctrl_q[CTRL_RAIL_LSB +: 4];

    // lengths scale by 1, 2, 4 or 8 from the selection field
    assign pok_len = CNT_W'(POK_CYC) << ctrl_q[CTRL_POK_LSB +: 2];
    assign rst_len = CNT_W'(RST_HOLD_CYC) << ctrl_q[CTRL_RST_LSB +: 2];

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_rail
            srp_margin_hold u_hold
            (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .freeze   (freeze),                  // [R1]
                .reading  (rail_in_window[g]),
                .eff_q    (rail_eff[g])
            );
            // counter clears whenever the rail falls out early
            srp_persist u_pok
            (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .cond     (rail_eff[g]),             // [R7] [R9]
                .len      (pok_len),                 // [R6]
                .ok_q     (pg_ok[g])
            );
        end
    endgenerate

    // ********************************************************
    // reset stretch
    // ********************************************************
    // tracking status only matters outside margin mode
    assign hold_req = ~manual_reset_n                // [R4]
                    | (tracking_busy & ~freeze)      // [R8] [R1]
                    | |(rail_sel & ~pg_ok);          // [R8]

    srp_persist u_rst
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .cond     (~hold_req),
        .len      (rst_len),                         // [R4] [R8]
        .ok_q     (rst_done)
    );

    always_comb
    begin
        sysrst_d = rst_done & ~hold_req;             // [R4]
        rst_st_d = SRP_RST_HOLD;
        if (hold_req)
        begin
            rst_st_d = SRP_RST_HOLD;
        end
        else if (rst_done)
        begin
            rst_st_d = SRP_RST_RUN;
        end
        else
        begin
            rst_st_d = SRP_RST_TIMING;
        end
        case (rst_st_q)
            SRP_RST_HOLD:   ;
            SRP_RST_TIMING: ;
            SRP_RST_RUN:    ;
            default:        rst_st_d = SRP_RST_HOLD;
        endcase
    end

    // ********************************************************
    // address straps and supply fault gating
    // ********************************************************
    always_comb
    begin
        addr_d      = addr_q;
        addr_done_d = 1'b1;
        if (!addr_done_q)
        begin
            addr_d = {addr_select1, addr_select0};   // [R5]
        end
        fault_d = supply_out_of_range & {4{~freeze}}; // [R1] [R2]
    end

    // ********************************************************
    // apb register file
    // ********************************************************
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & rdy_q;

    always_comb
    begin
        ctrl_d  = ctrl_q;
        thr_d   = thr_q;
        imask_d = imask_q;
        rdata_d = rdata_q;
        err_d   = 1'b0;
        rdy_d   = setup;
        if (setup)
        begin
            rdata_d = 32'h0000_0000;
            if (paddr == OFS_CTRL)
            begin
                rdata_d[7:0] = ctrl_q;
            end
            else if (paddr == OFS_STATUS)
            begin
                rdata_d[ST_PG_LSB +: 4]  = pg_ok;
                rdata_d[ST_RST_BIT]      = sysrst_q;
                rdata_d[ST_MARGIN_BIT]   = freeze;
                rdata_d[ST_ADDR_LSB +: 2] = addr_q;
                rdata_d[ST_FSM_LSB +: 2] = rst_st_q;
            end
            else if (paddr == OFS_IRQ_STAT)
            begin
                rdata_d[IRQ_W-1:0] = istat_q;
            end
            else if (paddr == OFS_IRQ_MASK)
            begin
                rdata_d[IRQ_W-1:0] = imask_q;
            end
            else if (paddr == OFS_PG_THR)
            begin
                rdata_d[15:0] = thr_q;
            end
            else
            begin
                err_d = 1'b1;
            end
        end
        else
        begin
            err_d = err_q & psel & penable & ~rdy_q;
        end
        if (wr_acc)
        begin
            if (paddr == OFS_CTRL)
            begin
                ctrl_d = pwdata[7:0];
            end
            else if (paddr == OFS_IRQ_MASK)
            begin
                imask_d = pwdata[IRQ_W-1:0];
            end
            else if (paddr == OFS_PG_THR)
            begin
                thr_d = pwdata[15:0];
            end
        end
    end

    // ********************************************************
    // interrupts
    // ********************************************************
    // a new event in the clearing cycle survives the clear
    always_comb
    begin
        istat_d = istat_q;
        if (wr_acc && paddr == OFS_IRQ_STAT)
        begin
            istat_d = istat_q & ~pwdata[IRQ_W-1:0];
        end
        istat_d[IRQ_PGLOST_LSB +: 4] = istat_d[IRQ_PGLOST_LSB +: 4]
                                     | (pg_prev_q & ~pg_ok);
        istat_d[IRQ_RST_BIT] = istat_d[IRQ_RST_BIT]
                             | (sysrst_q & ~sysrst_d);
        istat_d[IRQ_MARGIN_BIT] = istat_d[IRQ_MARGIN_BIT]
                                | (freeze & ~margin_prev_q);
        irq_d = |(istat_d & imask_q);
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl_q        <= CTRL_RESET;
            thr_q         <= PG_THR_RESET;
            istat_q       <= '0;
            imask_q       <= '0;
            rdata_q       <= 32'h0000_0000;
            rdy_q         <= 1'b0;
            err_q         <= 1'b0;
            irq_q         <= 1'b0;
            addr_q        <= 2'h0;
            addr_done_q   <= 1'b0;
            fault_q       <= 4'h0;
            pg_prev_q     <= 4'h0;
            sysrst_q      <= 1'b0;
            margin_prev_q <= 1'b0;
            rst_st_q      <= SRP_RST_HOLD;
        end
        else
        begin
            ctrl_q        <= ctrl_d;
            thr_q         <= thr_d;
            istat_q       <= istat_d;
            imask_q       <= imask_d;
            rdata_q       <= rdata_d;
            rdy_q         <= rdy_d;
            err_q         <= err_d;
            irq_q         <= irq_d;
            addr_q        <= addr_d;
            addr_done_q   <= addr_done_d;
            fault_q       <= fault_d;
            pg_prev_q     <= pg_ok;
            sysrst_q      <= sysrst_d;
            margin_prev_q <= freeze;
            rst_st_q      <= rst_st_d;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign prdata           = rdata_q;
    assign pready           = rdy_q;
    assign pslverr          = err_q;
    assign system_reset_n   = sysrst_q;
    assign power_good_rail1 = pg_ok[0];                  // [R7]
    assign power_good_rail2 = pg_ok[1];
    assign power_good_rail3 = pg_ok[2];
    assign power_good_rail4 = pg_ok[3];
    assign supply_fault     = fault_q;
    assign pg_threshold     = thr_q;
    assign bus_addr         = addr_q;
    assign irq              = irq_q;
endmodule

// file: tb/srp_chk_assertions.sv
/*
 * checker for the supervisor block: reset stretch, margin freeze,
 * power-good persistence and address strap capture.
 * assumes it is bound to srp_top and sees only its ports.
 */
`timescale 1ns/1ps
module srp_chk
#(
    parameter int RST_HOLD_CYC = 8,
    parameter int POK_CYC      = 5
)
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // system pins
    input wire logic       manual_reset_n,
    input wire logic       margin_n,
    input wire logic       addr_select0,
    input wire logic       addr_select1,
    input wire logic       system_reset_n,
    input wire logic       power_good_rail1,
    input wire logic       power_good_rail2,
    input wire logic       power_good_rail3,
    input wire logic       power_good_rail4,
    // analog side
    input wire logic [3:0] rail_in_window,
    input wire logic [3:0] supply_out_of_range,
    input wire logic       tracking_busy,
    input wire logic [3:0] supply_fault,
    input wire logic [1:0] bus_addr
);
    // ****************
    // run length of each raw rail reading, saturating
    // ****************
    logic [3:0] pg;
    // wide enough for the full-length delay as well
    logic [15:0] run_q [4];
    logic [15:0] run_d [4];
    assign pg = {power_good_rail4, power_good_rail3,
                 power_good_rail2, power_good_rail1};
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            run_d[i] = (run_q[i] == 16'hffff) ? run_q[i]
                                              : run_q[i] + 16'h0001;
            if (!rst_n || !rail_in_window[i])
                run_d[i] = 16'h0000;
        end
    end
    always_ff @(posedge core_clk)
        run_q <= run_d;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ****************
    // assertions
    // ****************
    for (genvar i = 0; i < 4; i++)
    begin : g_rail
        pg_rise_a: assert property ($rose(pg[i]) |-> run_q[i] > POK_CYC)
            else $error("power good rose before its delay");
        pg_drop_a: assert property ((margin_n && !rail_in_window[i])[*3]
            |-> !pg[i]) else $error("power good kept after its rail fell");
    end
    rst_manual_a: assert property (!manual_reset_n[*4] |-> !system_reset_n)
        else $error("manual reset not passed to reset output");
    rst_stretch_a: assert property (!system_reset_n && $rose(manual_reset_n)
        |-> !system_reset_n[*8]) else $error("reset released too soon");
    rst_track_a: assert property ((tracking_busy && margin_n)[*4]
        |-> !system_reset_n) else $error("reset high while tracking");
    rst_margin_a: assert property ((!margin_n && manual_reset_n &&
        system_reset_n && &pg)[*3] |=> system_reset_n)
        else $error("reset disturbed in margin mode");
    fault_mask_a: assert property (!margin_n[*2] |-> supply_fault == 4'h0)
        else $error("supply fault shown in margin mode");
    fault_pass_a: assert property (margin_n[*2] |->
        supply_fault == $past(supply_out_of_range))
        else $error("supply fault not following readings");
    addr_cap_a: assert property (rst_n[*3] |->
        bus_addr == {addr_select1, addr_select0})
        else $error("bus address differs from straps");
endmodule

bind srp_top srp_chk #(
    .RST_HOLD_CYC (RST_HOLD_CYC),
    .POK_CYC      (POK_CYC)
) u_srp_chk (
    .core_clk (core_clk), .rst_n (rst_n),
    .manual_reset_n (manual_reset_n), .margin_n (margin_n),
    .addr_select0 (addr_select0), .addr_select1 (addr_select1),
    .system_reset_n (system_reset_n),
    .power_good_rail1 (power_good_rail1),
    .power_good_rail2 (power_good_rail2),
    .power_good_rail3 (power_good_rail3),
    .power_good_rail4 (power_good_rail4),
    .rail_in_window (rail_in_window),
    .supply_out_of_range (supply_out_of_range),
    .tracking_busy (tracking_busy), .supply_fault (supply_fault),
    .bus_addr (bus_addr)
);

// file: tb/srp_host_model.sv
/*
 * host side model: drives the manual reset and margin pins.
 * assumes commands from the bench on core_clk.
 */
`timescale 1ns/1ps
module srp_host_model
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // bench commands
    input  wire logic mr_req,
    input  wire logic margin_req,
    // system status
    input  wire logic system_reset_n,
    // pins, pulled up while idle
    output logic      manual_reset_n,
    output logic      margin_n
);
    initial
    begin
        manual_reset_n = 1'b1;
        margin_n = 1'b1;
    end
    always @(posedge core_clk)
    begin
        manual_reset_n <= ~(mr_req & rst_n);
        // margin entered only once the system is up, left at any time
        margin_n <= ~(margin_req & rst_n &
                      (system_reset_n | ~margin_n));
    end
endmodule

// file: tb/testbench.sv
/*
 * self-checking bench for srp_top with a host model on its pins.
 * assumes short timing parameters so the run stays brief.
 */
`timescale 1ns/1ps
module testbench;
    import srp_pkg::*;
    localparam int RH = 8;
    localparam int PK = 5;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} srp_row_t;
    srp_row_t rows [5] = '{'{OFS_CTRL, {24'h0, CTRL_RESET}, 1'b0},
        '{OFS_STATUS, 32'h80, 1'b0}, '{OFS_IRQ_MASK, 32'h0, 1'b0},
        '{OFS_PG_THR, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b1}};
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, irq, system_reset_n;
    logic        mr_req = 1'b0, margin_req = 1'b0;
    logic        manual_reset_n, margin_n, pg1, pg2, pg3, pg4;
    logic [3:0]  rail = 4'h0, oor = 4'h0, supply_fault;
    logic        tracking_busy = 1'b1;
    logic [15:0] pg_threshold;
    logic [1:0]  bus_addr;
    logic [1:0]  straps = 2'b10;
    int          n_errors = 0, cmp_count = 0, wn;

    always #2 core_clk = ~core_clk;

    srp_top #(.RST_HOLD_CYC(RH), .POK_CYC(PK)) u_srp_top (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manual_reset_n(manual_reset_n),
        .margin_n(margin_n), .addr_select0(straps[0]),
        .addr_select1(straps[1]),
        .system_reset_n(system_reset_n), .power_good_rail1(pg1),
        .power_good_rail2(pg2), .power_good_rail3(pg3),
        .power_good_rail4(pg4), .rail_in_window(rail),
        .supply_out_of_range(oor), .tracking_busy(tracking_busy),
        .supply_fault(supply_fault), .pg_threshold(pg_threshold),
        .bus_addr(bus_addr), .irq(irq));
    srp_host_model u_srp_host_model (
        .core_clk(core_clk), .rst_n(rst_n), .mr_req(mr_req),
        .margin_req(margin_req), .system_reset_n(system_reset_n),
        .manual_reset_n(manual_reset_n), .margin_n(margin_n));

    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", pready, 1'b1);
    endtask

    task automatic wait_rst(input logic v);
        wn = 0;
        while (system_reset_n !== v && wn < 400)
        begin
            @(posedge core_clk);
            wn++;
        end
        chk("system_reset_n", system_reset_n, v);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        close_out();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        chk("reset_in_reset", system_reset_n, 1'b0);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("rdata", rd, rows[i].d);
            chk("pslverr", err, rows[i].e);
        end
        chk("bus_addr", bus_addr, 2'b10);
        apb(1'b1, OFS_PG_THR, 32'h1234);
        @(posedge core_clk);
        chk("pg_threshold", pg_threshold, 16'h1234);
        apb(1'b0, OFS_PG_THR, 32'h0);
        chk("pg_thr_rd", rd, 32'h1234);
        $display("test registers done");
        rail <= 4'hf;
        repeat (PK) @(posedge core_clk);
        chk("pg_early", pg1, 1'b0);
        repeat (12) @(posedge core_clk);
        chk("pg_all", {pg4, pg3, pg2, pg1}, 4'hf);
        chk("reset_tracking", system_reset_n, 1'b0);
        tracking_busy <= 1'b0;
        wait_rst(1'b1);
        $display("test power up done");
        rail <= 4'hd;
        repeat (4) @(posedge core_clk);
        chk("pg_own_rail", {pg4, pg3, pg2, pg1}, 4'hd);
        rail <= 4'hf;
        repeat (3) @(posedge core_clk);
        rail <= 4'hd;
        @(posedge core_clk);
        rail <= 4'hf;
        repeat (PK + 1) @(posedge core_clk);
        chk("pg_restart", pg2, 1'b0);
        repeat (8) @(posedge core_clk);
        chk("pg_back", pg2, 1'b1);
        wait_rst(1'b1);
        $display("test persistence done");
        // doubled reset hold through the scale field
        apb(1'b1, OFS_CTRL, {24'h0, CTRL_RESET} | (32'h1 << CTRL_RST_LSB));
        mr_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("reset_manual", system_reset_n, 1'b0);
        mr_req <= 1'b0;
        wait_rst(1'b1);
        chk("reset_stretch", wn > (RH << 1), 1'b1);
        $display("test manual reset done");
        margin_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        rail <= 4'he;
        oor <= 4'h5;
        tracking_busy <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk("pg_frozen", pg1, 1'b1);
        chk("reset_frozen", system_reset_n, 1'b1);
        chk("fault_masked", supply_fault, 4'h0);
        margin_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("fault_resumed", supply_fault, 4'h5);
        wait_rst(1'b0);
        chk("pg_resumed", pg1, 1'b0);
        rail <= 4'hf;
        oor <= 4'h0;
        tracking_busy <= 1'b0;
        wait_rst(1'b1);
        $display("test margin done");
        chk("irq_masked", irq, 1'b0);
        // pg lost on rails 1 and 2, reset fell, margin entered
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq_stat_set", rd, 32'h33);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("irq_raised", irq, 1'b1);
        apb(1'b1, OFS_IRQ_STAT, 32'h3f);
        repeat (3) @(posedge core_clk);
        chk("irq_cleared", irq, 1'b0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq_stat", rd, 32'h0);
        $display("test interrupt done");
        // second reset in mid-run with new straps
        rst_n <= 1'b0;
        straps <= 2'b01;
        repeat (2) @(posedge core_clk);
        chk("pg_in_reset", {pg4, pg3, pg2, pg1}, 4'h0);
        chk("irq_in_reset", irq, 1'b0);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("bus_addr_new", bus_addr, 2'b01);
        chk("reset_after_rst", system_reset_n, 1'b0);
        wait_rst(1'b1);
        $display("test second reset done");
        close_out();
    end
endmodule
